// [hdl/psc_pkg.sv]
package psc_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned DATA_W = 12;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS_1 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS_2 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_DRIVER_CONTROL = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OVERCURRENT_PROTECTION_CONTROL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_SENSE_AMPLIFIER_CONTROL = 3'h4;

  // ==========================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_DRIVER_CONTROL = 12'h3A4;
  localparam logic [DATA_W-1:0] RST_OVERCURRENT_PROTECTION_CONTROL = 12'h250;
  localparam logic [DATA_W-1:0] RST_SENSE_AMPLIFIER_CONTROL = 12'hB02;

  // ==========================================================
  // Field positions
  localparam int unsigned FS1_DS_FLAG_BIT = 7;
  localparam int unsigned FS1_SHUNT_FLAG_BIT = 6;
  localparam int unsigned CTL_CLEAR_BIT = 11;
  localparam int unsigned CTL_LOCK_LSB = 8;
  localparam int unsigned OCP_DS_MODE_LSB = 10;
  localparam int unsigned OCP_DS_TRIP_LSB = 6;
  localparam int unsigned OCP_DEGLITCH_LSB = 4;
  localparam int unsigned OCP_DS_RETRY_BIT = 3;
  localparam int unsigned OCP_SHUNT_RETRY_BIT = 2;
  localparam int unsigned OCP_SHUNT_MODE_LSB = 0;
  localparam int unsigned SNS_SHUNT_TRIP_LSB = 9;
  localparam int unsigned SNS_GAIN_LSB = 7;
  localparam int unsigned SNS_CAL_LSB = 4;
  localparam int unsigned SNS_EMF_EN_BIT = 3;
  localparam int unsigned SNS_EMF_GAIN_LSB = 1;
  localparam int unsigned SNS_COMMON_BIT = 0;

  // ==========================================================
  // Codes
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_IGNORE = 2'h3;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DEGLITCH_0_NS = 1400;
  localparam int unsigned DEGLITCH_1_NS = 2200;
  localparam int unsigned DEGLITCH_2_NS = 3200;
  localparam int unsigned DEGLITCH_3_NS = 5400;
  localparam int unsigned DEG0_CYC = (DEGLITCH_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG1_CYC = (DEGLITCH_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG2_CYC = (DEGLITCH_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG3_CYC = (DEGLITCH_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG_CNT_W = 6;
  localparam int unsigned RETRY_SHORT_NS = 70000;
  localparam int unsigned RETRY_LONG_NS = 4000000;
  localparam int unsigned RETRY_SHORT_CYC = (RETRY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_LONG_CYC = (RETRY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CNT_W = 16;

  typedef enum logic [1:0] {
    PSC_ARMED,
    PSC_TRIPPED,
    PSC_WAIT
  } psc_path_state_e;

endpackage : psc_pkg

// [hdl/psc_protection_sense_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_protection_sense_regs
  import psc_pkg::*;
#(
  parameter int unsigned LONG_RETRY_CYCLES = RETRY_LONG_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic enable_pin_in,
  input wire logic [5:0] ds_compare_in,
  input wire logic [2:0] shunt_compare_in,
  input wire logic [2:0] cal_done_in,
  output logic fault_out_n,
  output logic gate_enable_out,
  output logic [3:0] drain_source_trip_level_out,
  output logic [2:0] shunt_trip_level_out,
  output logic [1:0] amp_gain_out,
  output logic back_emf_sense_enable_out,
  output logic [1:0] back_emf_gain_out,
  output logic common_sel_out,
  output logic cal_amp_a_start_out,
  output logic cal_amp_b_start_out,
  output logic cal_amp_c_start_out,
  output logic cal_emf_start_out
);

  // ==========================================================
  // Decoders
  function automatic logic [DEG_CNT_W-1:0] deg_cycles(input logic [1:0] code);
    case (code)
      2'h0: deg_cycles = DEG_CNT_W'(DEG0_CYC);
      2'h1: deg_cycles = DEG_CNT_W'(DEG1_CYC);
      2'h2: deg_cycles = DEG_CNT_W'(DEG2_CYC);
      default: deg_cycles = DEG_CNT_W'(DEG3_CYC);
    endcase
  endfunction : deg_cycles

  function automatic logic [RETRY_CNT_W-1:0] retry_load(input logic short_sel);
    retry_load = short_sel ? RETRY_CNT_W'(RETRY_SHORT_CYC - 1)
                           : RETRY_CNT_W'(LONG_RETRY_CYCLES - 1);
  endfunction : retry_load

  // ==========================================================
  // Pin synchronisers
  localparam int unsigned SYNC_W = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1800;
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic sclk_prev_q, cs_prev_q, en_prev_q;
  logic sdi_s, sclk_s, cs_s, en_s;
  logic [5:0] ds_s;
  logic [2:0] shunt_s;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      en_prev_q <= 1'b1;
    end else if (ce_in) begin
      sync1_q <= {spi_cs_n_in, enable_pin_in, spi_sclk_in, spi_sdi_in,
                  ds_compare_in, shunt_compare_in};
      sync2_q <= sync1_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
      en_prev_q <= en_s;
    end
  end

  assign {cs_s, en_s, sclk_s, sdi_s, ds_s, shunt_s} = sync2_q;

  // ==========================================================
  // Serial port
  logic [FRAME_BITS-1:0] shin_q, shin_d;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic [DATA_W-1:0] shout_q, shout_d;
  logic sdo_q, sdo_d, oe_q, oe_d, wr_stb_q, wr_stb_d;
  logic [DATA_W-1:0] ctl_q, ocp_q, sns_q;
  logic [1:0] flag_q;
  logic [5:0] ds_fet_q;
  logic [2:0] shunt_amp_q;

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      ADDR_FAULT_STATUS_1: begin
        w[FS1_DS_FLAG_BIT] = flag_q[0];
        w[FS1_SHUNT_FLAG_BIT] = flag_q[1];
      end
      ADDR_FAULT_STATUS_2: w = {shunt_amp_q, ds_fet_q, 3'h0};
      ADDR_DRIVER_CONTROL: w = {1'b0, ctl_q[10:0]};
      ADDR_OVERCURRENT_PROTECTION_CONTROL: w = ocp_q;
      ADDR_SENSE_AMPLIFIER_CONTROL: w = sns_q;
      default: w = '0;
    endcase
    read_word = w;
  endfunction : read_word

  always_comb begin
    shin_d = shin_q;
    bitcnt_d = bitcnt_q;
    shout_d = shout_q;
    sdo_d = sdo_q;
    oe_d = ~cs_s;
    wr_stb_d = 1'b0;
    if (cs_s) begin
      bitcnt_d = 5'h0;
      sdo_d = 1'b0;
      if (!cs_prev_q && bitcnt_q == 5'(FRAME_BITS) && !shin_q[FRAME_BITS-1]) begin
        wr_stb_d = 1'b1;
      end
    end else if (sclk_s && !sclk_prev_q && bitcnt_q < 5'(FRAME_BITS)) begin
      shin_d = {shin_q[FRAME_BITS-2:0], sdi_s};
      bitcnt_d = bitcnt_q + 5'h1;
      if (bitcnt_q == 5'h3) begin
        shout_d = read_word({shin_q[1:0], sdi_s});
      end
    end else if (!sclk_s && sclk_prev_q && bitcnt_q >= 5'h4 && bitcnt_q < 5'(FRAME_BITS)) begin
      sdo_d = shout_q[DATA_W-1];
      shout_d = {shout_q[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shin_q <= '0;
      bitcnt_q <= 5'h0;
      shout_q <= '0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else if (ce_in) begin
      shin_q <= shin_d;
      bitcnt_q <= bitcnt_d;
      shout_q <= shout_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      wr_stb_q <= wr_stb_d;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [DATA_W-1:0] ctl_d, ocp_d, sns_d;
  logic clr_q, clr_d;
  logic [3:0] cal_go_q, cal_go_d;
  logic locked;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [2:0] cal_set;

  assign wr_addr = shin_q[DATA_W+ADDR_W-1:DATA_W];
  assign wr_data = shin_q[DATA_W-1:0];
  assign locked = ctl_q[CTL_LOCK_LSB+2:CTL_LOCK_LSB] == LOCK_CODE;

  always_comb begin
    ctl_d = ctl_q;
    ocp_d = ocp_q;
    sns_d = sns_q;
    clr_d = 1'b0;
    cal_set = 3'h0;
    if (wr_stb_q) begin
      case (wr_addr)
        ADDR_DRIVER_CONTROL: begin
          if (wr_data[CTL_LOCK_LSB+2:CTL_LOCK_LSB] == LOCK_CODE ||
              wr_data[CTL_LOCK_LSB+2:CTL_LOCK_LSB] == UNLOCK_CODE) begin
            ctl_d[CTL_LOCK_LSB+2:CTL_LOCK_LSB] = wr_data[CTL_LOCK_LSB+2:CTL_LOCK_LSB];
          end
          if (!locked) begin
            ctl_d[CTL_LOCK_LSB-1:0] = wr_data[CTL_LOCK_LSB-1:0];
            clr_d = wr_data[CTL_CLEAR_BIT];
          end
        end
        ADDR_OVERCURRENT_PROTECTION_CONTROL: begin
          if (!locked) begin
            ocp_d = wr_data;
          end
        end
        ADDR_SENSE_AMPLIFIER_CONTROL: begin
          if (!locked) begin
            sns_d[DATA_W-1:SNS_CAL_LSB+3] = wr_data[DATA_W-1:SNS_CAL_LSB+3];
            sns_d[SNS_CAL_LSB-1:0] = wr_data[SNS_CAL_LSB-1:0];
            cal_set = wr_data[SNS_CAL_LSB+2:SNS_CAL_LSB];
          end
        end
        default: ;
      endcase
    end
    // Hardware clears on done, a fresh write of 1 wins
    sns_d[SNS_CAL_LSB+2:SNS_CAL_LSB] =
      (sns_q[SNS_CAL_LSB+2:SNS_CAL_LSB] & ~cal_done_in) | cal_set;
    cal_go_d[0] = cal_set[2] & ~sns_q[SNS_CAL_LSB+2];
    cal_go_d[1] = cal_set[1] & ~sns_q[SNS_CAL_LSB+1];
    cal_go_d[2] = cal_set[0] & ~sns_q[SNS_CAL_LSB] & ~sns_d[SNS_EMF_EN_BIT];
    cal_go_d[3] = cal_set[0] & ~sns_q[SNS_CAL_LSB] & sns_d[SNS_EMF_EN_BIT];
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_q <= RST_DRIVER_CONTROL;
      ocp_q <= RST_OVERCURRENT_PROTECTION_CONTROL;
      sns_q <= RST_SENSE_AMPLIFIER_CONTROL;
      clr_q <= 1'b0;
      cal_go_q <= 4'h0;
    end else if (ce_in) begin
      ctl_q <= ctl_d;
      ocp_q <= ocp_d;
      sns_q <= sns_d;
      clr_q <= clr_d;
      cal_go_q <= cal_go_d;
    end
  end

  // ==========================================================
  // Overcurrent paths: 0 drain-source, 1 shunt
  logic [1:0] raw, det, armed;
  logic [1:0] path_mode [2];
  logic [1:0] path_short;
  logic clear_all;

  assign raw = {|shunt_s, |ds_s};
  assign path_mode[0] = ocp_q[OCP_DS_MODE_LSB+1:OCP_DS_MODE_LSB];
  assign path_mode[1] = ocp_q[OCP_SHUNT_MODE_LSB+1:OCP_SHUNT_MODE_LSB];
  assign path_short = {ocp_q[OCP_SHUNT_RETRY_BIT], ocp_q[OCP_DS_RETRY_BIT]};
  assign clear_all = clr_q | (en_s & ~en_prev_q);

  generate
    for (genvar p = 0; p < 2; p++) begin : g_path
      logic [DEG_CNT_W-1:0] dg_q, dg_d, thr;
      logic [RETRY_CNT_W-1:0] rt_q, rt_d;
      psc_path_state_e st_q, st_d;

      assign thr = deg_cycles(ocp_q[OCP_DEGLITCH_LSB+1:OCP_DEGLITCH_LSB]);
      assign det[p] = dg_q >= thr;
      assign armed[p] = st_q == PSC_ARMED;

      always_comb begin
        dg_d = !raw[p] ? '0 : (dg_q >= thr ? thr : dg_q + DEG_CNT_W'(1));
        st_d = st_q;
        rt_d = rt_q;
        case (st_q)
          PSC_ARMED: begin
            if (det[p] && path_mode[p] == MODE_LATCH) begin
              st_d = PSC_TRIPPED;
            end else if (det[p] && path_mode[p] == MODE_RETRY) begin
              st_d = PSC_WAIT;
              rt_d = retry_load(path_short[p]);
            end
          end
          PSC_TRIPPED: begin
            if (clear_all) begin
              st_d = PSC_ARMED;
            end
          end
          PSC_WAIT: begin
            if (clear_all) begin
              st_d = PSC_ARMED;
            end else if (rt_q != '0) begin
              rt_d = rt_q - RETRY_CNT_W'(1);
            end else if (det[p]) begin
              rt_d = retry_load(path_short[p]);
            end else begin
              st_d = PSC_ARMED;
            end
          end
          default: st_d = PSC_ARMED;
        endcase
      end

      always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
          dg_q <= '0;
          rt_q <= '0;
          st_q <= PSC_ARMED;
        end else if (ce_in) begin
          dg_q <= dg_d;
          rt_q <= rt_d;
          st_q <= st_d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Fault flags, pin and driver enable
  logic [1:0] flag_d;
  logic [5:0] ds_fet_d;
  logic [2:0] shunt_amp_d;
  logic fault_n_q, fault_n_d, gate_en_q, gate_en_d;

  always_comb begin
    // Set wins over clear; flags set in every mode
    flag_d = (clear_all ? 2'h0 : flag_q) | det;
    ds_fet_d = (clear_all ? 6'h0 : ds_fet_q) | (det[0] ? ds_s : 6'h0);
    shunt_amp_d = (clear_all ? 3'h0 : shunt_amp_q) | (det[1] ? shunt_s : 3'h0);
    fault_n_d = ~((flag_q[0] && path_mode[0] != MODE_IGNORE) ||
                  (flag_q[1] && path_mode[1] != MODE_IGNORE));
    gate_en_d = &armed;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_q <= 2'h0;
      ds_fet_q <= 6'h0;
      shunt_amp_q <= 3'h0;
      fault_n_q <= 1'b1;
      gate_en_q <= 1'b1;
    end else if (ce_in) begin
      flag_q <= flag_d;
      ds_fet_q <= ds_fet_d;
      shunt_amp_q <= shunt_amp_d;
      fault_n_q <= fault_n_d;
      gate_en_q <= gate_en_d;
    end
  end

  // ==========================================================
  // Outputs
  assign spi_sdo_out = sdo_q;
  assign spi_sdo_oe_out = oe_q;
  assign fault_out_n = fault_n_q;
  assign gate_enable_out = gate_en_q;
  assign drain_source_trip_level_out = ocp_q[OCP_DS_TRIP_LSB+3:OCP_DS_TRIP_LSB];
  assign shunt_trip_level_out = sns_q[SNS_SHUNT_TRIP_LSB+2:SNS_SHUNT_TRIP_LSB];
  assign amp_gain_out = sns_q[SNS_GAIN_LSB+1:SNS_GAIN_LSB];
  assign back_emf_sense_enable_out = sns_q[SNS_EMF_EN_BIT];
  assign back_emf_gain_out = sns_q[SNS_EMF_GAIN_LSB+1:SNS_EMF_GAIN_LSB];
  assign common_sel_out = sns_q[SNS_COMMON_BIT];
  assign cal_amp_a_start_out = cal_go_q[0];
  assign cal_amp_b_start_out = cal_go_q[1];
  assign cal_amp_c_start_out = cal_go_q[2];
  assign cal_emf_start_out = cal_go_q[3];

endmodule : psc_protection_sense_regs
`default_nettype wire

// [tb/psc_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial host model
module psc_spi_host (
  input wire logic clock_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // One 16-bit frame, six clocks low and four high per bit
  task automatic xfer(input logic [15:0] w, output logic [11:0] rd);
    rd = 12'h000;
    @(negedge clock_in) cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clock_in) sdi_out <= w[i];
      repeat (5) @(negedge clock_in);
      if (i < 12) rd[i] = sdo_in;
      sclk_out <= 1'b1;
      repeat (4) @(negedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(negedge clock_in);
    cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    repeat (8) @(negedge clock_in);
  endtask : xfer
endmodule : psc_spi_host
`default_nettype wire

// [tb/psc_protection_sense_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module psc_protection_sense_regs_assertions
  import psc_pkg::*;
#(
  parameter int unsigned LONG_RETRY_CYCLES = RETRY_LONG_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdo_oe_out,
  input wire logic [5:0] ds_compare_in,
  input wire logic [2:0] shunt_compare_in,
  input wire logic fault_out_n,
  input wire logic gate_enable_out,
  input wire logic [3:0] drain_source_trip_level_out,
  input wire logic [2:0] shunt_trip_level_out,
  input wire logic [1:0] amp_gain_out,
  input wire logic back_emf_sense_enable_out,
  input wire logic cal_amp_a_start_out,
  input wire logic cal_amp_c_start_out,
  input wire logic cal_emf_start_out
);
  localparam int MIN_LOW = (LONG_RETRY_CYCLES < 700) ? LONG_RETRY_CYCLES : 700;
  logic any_cmp;
  logic [15:0] low_cnt_d, low_cnt_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  assign any_cmp = (|ds_compare_in) | (|shunt_compare_in);

  // Cycles the drivers have been held off
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (gate_enable_out) low_cnt_d = 16'h0000;
    else if (low_cnt_q != 16'hFFFF) low_cnt_d = low_cnt_q + 16'h0001;
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) low_cnt_q <= 16'h0000;
    else low_cnt_q <= low_cnt_d;
  end

  a_reset_levels: assert property ($rose(rstn_in) |-> drain_source_trip_level_out == 4'h9
    && shunt_trip_level_out == 3'h5 && amp_gain_out == 2'h2) else $error("bad reset levels");
  a_oe_idle: assert property (spi_cs_n_in [*4] |-> !spi_sdo_oe_out)
    else $error("sdo enabled while deselected");
  a_oe_active: assert property (!spi_cs_n_in [*4] |-> spi_sdo_oe_out)
    else $error("sdo not enabled while selected");
  a_cal_single: assert property (cal_amp_a_start_out |=> !cal_amp_a_start_out)
    else $error("calibrate pulse too long");
  a_cal_after_write: assert property (cal_amp_a_start_out |-> spi_cs_n_in
    && $past(spi_cs_n_in, 4)) else $error("calibrate start outside write");
  a_cal_c_select: assert property (cal_amp_c_start_out |-> !back_emf_sense_enable_out)
    else $error("amp C calibrated in emf mode");
  a_cal_emf_select: assert property (cal_emf_start_out |-> back_emf_sense_enable_out)
    else $error("emf calibrated with emf off");
  a_gate_cause: assert property ($fell(gate_enable_out) |-> $past(any_cmp, 5))
    else $error("drivers off without overcurrent");
  a_fault_with_gate: assert property ($fell(gate_enable_out) |-> !fault_out_n)
    else $error("drivers off without fault pin");
  a_gate_low_min: assert property ($rose(gate_enable_out)
    |-> low_cnt_q >= 16'(MIN_LOW - 2)) else $error("drivers back too soon");
  a_trip_after_write: assert property ($changed(drain_source_trip_level_out)
    |-> $past(spi_cs_n_in) && $past(spi_cs_n_in, 3)) else $error("trip changed mid frame");
endmodule : psc_protection_sense_regs_assertions

bind psc_protection_sense_regs psc_protection_sense_regs_assertions #(
  .LONG_RETRY_CYCLES(LONG_RETRY_CYCLES)
) psc_protection_sense_regs_assertions_inst (
  .clock_in, .rstn_in, .spi_cs_n_in, .spi_sdo_oe_out, .ds_compare_in, .shunt_compare_in,
  .fault_out_n, .gate_enable_out, .drain_source_trip_level_out, .shunt_trip_level_out,
  .amp_gain_out, .back_emf_sense_enable_out, .cal_amp_a_start_out, .cal_amp_c_start_out,
  .cal_emf_start_out
);
`default_nettype wire

// [tb/tb_protection_sense_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_protection_sense_config_regs
  import psc_pkg::*;
;
  localparam int LRC = 50;
  localparam int LIMIT = 40000;
  localparam logic [2:0] OCP = ADDR_OVERCURRENT_PROTECTION_CONTROL;
  localparam logic [2:0] SNS = ADDR_SENSE_AMPLIFIER_CONTROL;
  localparam logic [2:0] DRV = ADDR_DRIVER_CONTROL;
  logic clock_in, rstn_in, enable_pin_in, sclk, cs_n, sdi, sdo, sdo_oe, fault_n, gate;
  logic emf_en, com, cal_a, cal_b, cal_c, cal_e;
  logic [5:0] ds_compare_in;
  logic [2:0] shunt_compare_in, cal_done_in, strip;
  logic [3:0] trip;
  logic [1:0] gain, emf_gain;
  logic [11:0] rv;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int pc [4] = '{0, 0, 0, 0};

  // ==========================================================
  // Clock, instances, monitors
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  psc_protection_sense_regs #(.LONG_RETRY_CYCLES(LRC)) psc_protection_sense_regs_inst (
    .clock_in(clock_in), .rstn_in(rstn_in), .ce_in(1'b1), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
    .enable_pin_in(enable_pin_in), .ds_compare_in(ds_compare_in),
    .shunt_compare_in(shunt_compare_in), .cal_done_in(cal_done_in), .fault_out_n(fault_n),
    .gate_enable_out(gate), .drain_source_trip_level_out(trip),
    .shunt_trip_level_out(strip), .amp_gain_out(gain), .back_emf_sense_enable_out(emf_en),
    .back_emf_gain_out(emf_gain), .common_sel_out(com), .cal_amp_a_start_out(cal_a),
    .cal_amp_b_start_out(cal_b), .cal_amp_c_start_out(cal_c), .cal_emf_start_out(cal_e)
  );

  psc_spi_host psc_spi_host_inst (
    .clock_in(clock_in), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo)
  );

  always @(posedge clock_in) begin
    cycles++;
    if (cal_a === 1'b1) pc[0]++;
    if (cal_b === 1'b1) pc[1]++;
    if (cal_c === 1'b1) pc[2]++;
    if (cal_e === 1'b1) pc[3]++;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    psc_spi_host_inst.xfer({1'b0, a, d}, rv);
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [11:0] exp);
    psc_spi_host_inst.xfer({1'b1, a, 12'h000}, rv);
    check(rv, exp, "register read");
  endtask : rdchk

  task automatic drive(input int p, input logic on);
    @(negedge clock_in);
    if (p == 1) ds_compare_in <= on ? 6'h20 : 6'h00;
    else shunt_compare_in <= on ? 3'h4 : 3'h0;
  endtask : drive

  task automatic fire(input int p, input int len);
    drive(p, 1'b1);
    repeat (len - 1) @(negedge clock_in);
    drive(p, 1'b0);
    repeat (6) @(negedge clock_in);
  endtask : fire

  task automatic wait_gate(input logic lvl, input int lim, output int n);
    n = 0;
    while (gate !== lvl && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask : wait_gate

  task automatic done_pulse(input logic [2:0] m);
    @(negedge clock_in) cal_done_in <= m;
    @(negedge clock_in) cal_done_in <= 3'h0;
  endtask : done_pulse

  function automatic logic [11:0] ocp(input int dm, input int dr, input int sr, input int sm);
    return {2'(dm), 4'h9, 2'b00, 1'(dr), 1'(sr), 2'(sm)};
  endfunction : ocp

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk(OCP, 12'h250);
    rdchk(SNS, 12'hB02);
    rdchk(DRV, 12'h3A4);
    rdchk(3'h7, 12'h000);
    check({gate, fault_n}, 2'b11, "idle fault outputs");
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    logic [11:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {2'(k), 1'(k >> 1), 2'(k), 3'b000, 1'b0, 2'(k), 1'(k)};
      wr(SNS, v);
      check(strip, v[11:9], "shunt trip level");
      check(gain, v[8:7], "amp gain");
      check(emf_gain, v[2:1], "emf gain");
      check(com, v[0], "common select");
      rdchk(SNS, v);
    end
    for (int k = 0; k < 2; k++) begin
      v = (k == 1) ? 12'h3C8 : 12'h014;
      wr(OCP, v);
      check(trip, (k == 1) ? 4'hF : 4'h0, "drain-source trip level");
      rdchk(OCP, v);
    end
    wr(SNS, 12'hB02);
    $display("test fields done");
  endtask : t_fields

  task automatic t_cal;
    wr(SNS, 12'hB42);
    check(12'(pc[0]), 12'h001, "amp A start");
    rdchk(SNS, 12'hB42);
    wr(SNS, 12'hB02);
    rdchk(SNS, 12'hB42);
    done_pulse(3'h4);
    rdchk(SNS, 12'hB02);
    wr(SNS, 12'hB22);
    check(12'(pc[1]), 12'h001, "amp B start");
    done_pulse(3'h2);
    wr(SNS, 12'hB12);
    check(12'(pc[2]), 12'h001, "amp C start");
    done_pulse(3'h1);
    wr(SNS, 12'hB0A);
    check(emf_en, 1'b1, "emf enable");
    wr(SNS, 12'hB1A);
    check(12'(pc[3]), 12'h001, "emf start");
    check(12'(pc[2]), 12'h001, "amp C idle in emf mode");
    done_pulse(3'h1);
    rdchk(SNS, 12'hB0A);
    wr(SNS, 12'hB02);
    $display("test calibration done");
  endtask : t_cal

  task automatic t_lock;
    wr(DRV, 12'h6A4);
    wr(OCP, 12'h000);
    rdchk(OCP, 12'h3C8);
    wr(DRV, 12'h5A4);
    rdchk(DRV, 12'h6A4);
    wr(DRV, 12'h3A4);
    wr(OCP, 12'h000);
    rdchk(OCP, 12'h000);
    $display("test lock done");
  endtask : t_lock

  task automatic t_modes;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        if (m == 1) continue;
        wr(OCP, (p == 1) ? ocp(m, 0, 0, 3) : ocp(3, 0, 0, m));
        fire(p, 30);
        check(gate, m != 0, "drivers after fault");
        check(fault_n, m == 3, "fault pin");
        rdchk(ADDR_FAULT_STATUS_1, (p == 1) ? 12'h080 : 12'h040);
        rdchk(ADDR_FAULT_STATUS_2, (p == 1) ? 12'h100 : 12'h800);
        if (m == 0 && p == 0) begin
          @(negedge clock_in) enable_pin_in <= 1'b0;
          repeat (5) @(negedge clock_in);
          enable_pin_in <= 1'b1;
          repeat (8) @(negedge clock_in);
        end else begin
          wr(DRV, 12'hBA4);
        end
        check({gate, fault_n}, 2'b11, "after clear");
        rdchk(ADDR_FAULT_STATUS_1, 12'h000);
      end
    end
    rdchk(DRV, 12'h3A4);
    $display("test modes done");
  endtask : t_modes

  task automatic t_deglitch;
    int nd [4] = '{DEG0_CYC, DEG1_CYC, DEG2_CYC, DEG3_CYC};
    for (int d = 0; d < 4; d++) begin
      wr(OCP, {MODE_LATCH, 4'h9, 2'(d), 2'b00, MODE_IGNORE});
      fire(1, nd[d] - 4);
      check(gate, 1'b1, "short overcurrent ignored");
      fire(1, nd[d] + 4);
      check(gate, 1'b0, "long overcurrent trips");
      wr(DRV, 12'hBA4);
    end
    $display("test deglitch done");
  endtask : t_deglitch

  task automatic t_retry;
    int n, d;
    for (int p = 0; p < 2; p++) begin
      d = (p == 1) ? 700 : LRC;
      wr(OCP, (p == 1) ? ocp(1, 1, 0, 3) : ocp(3, 0, 0, 1));
      drive(p, 1'b1);
      wait_gate(1'b0, 100, n);
      drive(p, 1'b0);
      check(fault_n, 1'b0, "fault pin in retry");
      wait_gate(1'b1, d + 100, n);
      check(n >= d - 3 && n <= d + 2, 1'b1, "retry delay");
      drive(p, 1'b1);
      wait_gate(1'b0, 100, n);
      repeat (d + 30) @(negedge clock_in);
      check(gate, 1'b0, "persistent fault holds");
      drive(p, 1'b0);
      wait_gate(1'b1, 2 * d + 100, n);
      check(gate, 1'b1, "recovery after fault ends");
      wr(DRV, 12'hBA4);
    end
    $display("test retry done");
  endtask : t_retry

  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rstn_in = 1'b0;
    enable_pin_in = 1'b1;
    ds_compare_in = 6'h00;
    shunt_compare_in = 3'h0;
    cal_done_in = 3'h0;
    repeat (3) @(negedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(negedge clock_in);
    t_reset();
    t_fields();
    t_cal();
    t_lock();
    t_modes();
    t_deglitch();
    t_retry();
    print_verdict();
  end
endmodule : tb_protection_sense_config_regs
`default_nettype wire
